//--- osd_consts.svh
// Purpose: Constants for the oversample decimator.
// Assumes: 12-bit unsigned conversion results, 40 MHz system clock.
// Notes:   Included by every other file of the project, bench and ADC model too.
`ifndef OSD_CONSTS_SVH
`define OSD_CONSTS_SVH
`define OSD_SAMPLE_W    12
`define OSD_SUM_W       16
`define OSD_MAX_VBITS   2
`define OSD_VBITS_W     2
`define OSD_ROUND_BIT   3
`define OSD_MODE_W      2
`define OSD_RST_VBITS   2'h2
`define OSD_RST_MODE    2'h0
`endif

//--- osd_pkg.sv
// Purpose: Types for the oversample decimator.
// Assumes: Constants come from osd_consts.svh.
// Notes:   Holds types only.
`include "osd_consts.svh"
package osd_pkg;
   typedef enum logic [`OSD_MODE_W-1:0] {
      OSD_TRUNC = 2'h0,
      OSD_ROUND = 2'h1,
      OSD_EXTEND = 2'h2
   } osd_mode_t;
endpackage : osd_pkg

//--- osd_reduce.sv
// Purpose: Reduces an interval sum to the output word for the chosen mode.
// Assumes: Sum is the plain total of 4**n samples, n = vbits.
// Notes:   Purely combinational; the caller registers the result.
`include "osd_consts.svh"
module osd_reduce (
   input  wire logic [`OSD_SUM_W-1:0]   sum,
   input  wire logic [`OSD_VBITS_W-1:0] vbits,
   input  wire osd_pkg::osd_mode_t      mode,
   output logic      [`OSD_SUM_W-1:0]   word
);
   logic [`OSD_SUM_W-1:0] scaled;
   logic [`OSD_SUM_W-1:0] aligned;
   always_comb begin
      // Divide by 2**n, giving 12+n significant bits.
      scaled = sum >> vbits;
      // Align to the 16-bit frame so upper bits are the native 12.
      aligned = scaled << (`OSD_MAX_VBITS * 2 - vbits);
      unique case (mode)
         osd_pkg::OSD_TRUNC:
            word = {4'h0, aligned[`OSD_SUM_W-1:4]};
         osd_pkg::OSD_ROUND:
            // A full-scale sum saturates instead of wrapping to zero.
            word = (aligned[`OSD_SUM_W-1:4] == 12'hFFF) ?
                   16'h0FFF :
                   {4'h0, aligned[`OSD_SUM_W-1:4]
                          + {11'h000, aligned[`OSD_ROUND_BIT]}};
         default:
            // Extended keeps all 12+n bits of the kept sum, low-aligned.
            word = scaled;
      endcase
   end
endmodule : osd_reduce

//--- osd_decimator.sv
// Purpose: Sums 4**n ADC results per interval and emits one reduced word.
// Assumes: Results arrive as one-cycle strobes on sys_clk from on-chip logic.
// Notes:   Configuration inputs are sampled only at interval starts.
`include "osd_consts.svh"
module osd_decimator (
   input  wire logic                     sys_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     adc_valid,
   input  wire logic [`OSD_SAMPLE_W-1:0] adc_result,
   input  wire logic [`OSD_VBITS_W-1:0]  cfg_vbits,
   input  wire osd_pkg::osd_mode_t       cfg_mode,
   input  wire logic                     cfg_interleave,
   output logic      [`OSD_SUM_W-1:0]    out_data,
   output logic                          out_valid,
   output logic                          out_is_raw
);
   // Settings are held in the state, so a change in mid-interval only
   // takes effect at the next interval start.
   typedef struct packed {
      logic [`OSD_SUM_W-1:0]   acc;
      logic [`OSD_SUM_W-1:0]   cnt;
      logic [`OSD_VBITS_W-1:0] vbits;
      osd_pkg::osd_mode_t      mode;
      logic                    ilv;
      logic [`OSD_SUM_W-1:0]   data;
      logic                    valid;
      logic                    is_raw;
      logic                    done;
   } osd_state_t;

   osd_state_t st_r;
   osd_state_t st_nxt;
   logic [`OSD_SUM_W-1:0] last_count;
   logic [`OSD_SUM_W-1:0] total;
   logic [`OSD_SUM_W-1:0] reduced;
   logic [`OSD_VBITS_W-1:0] eff_vbits;
   logic                    start;
   logic [`OSD_VBITS_W-1:0] cur_vbits;
   osd_pkg::osd_mode_t      cur_mode;
   logic                    cur_ilv;
   logic                    last_sample;

   // The first sample of an interval already belongs to the new settings,
   // so they come straight from the inputs then; later samples of the
   // interval use the copy latched with that first sample.
   assign start = (st_r.cnt == 16'h0000);
   assign cur_vbits = start ? cfg_vbits : st_r.vbits;
   assign cur_mode = start ? cfg_mode : st_r.mode;
   assign cur_ilv = start ? cfg_interleave : st_r.ilv;
   // Above two virtual bits the 16-bit frame would overflow, so clamp.
   assign eff_vbits = (cur_vbits > `OSD_VBITS_W'(`OSD_MAX_VBITS)) ?
                      `OSD_VBITS_W'(`OSD_MAX_VBITS) : cur_vbits;
   // One less than 4**n, so the compare hits on the interval's last sample.
   assign last_count = (16'h0001 << (eff_vbits * 2)) - 16'h0001;
   assign last_sample = adc_valid && (st_r.cnt == last_count);
   assign total = st_r.acc + {4'h0, adc_result};

   // The word is reduced from this cycle's total, so it is registered on
   // the same edge that takes the interval's last sample.
   osd_reduce u_reduce (
      .sum   (total),
      .vbits (eff_vbits),
      .mode  (cur_mode),
      .word  (reduced)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.valid = 1'b0;
      st_nxt.is_raw = 1'b0;
      st_nxt.done = 1'b0;
      if (adc_valid) begin
         if (start) begin
            st_nxt.vbits = cfg_vbits;
            st_nxt.mode = cfg_mode;
            st_nxt.ilv = cfg_interleave;
         end
         // The last sample is never emitted raw: its slot carries the
         // decimated word, which keeps the interleaved output at one word per sample.
         if (st_r.cnt == last_count) begin
            st_nxt.acc = 16'h0000;
            st_nxt.cnt = 16'h0000;
            st_nxt.data = reduced;
            st_nxt.valid = 1'b1;
            st_nxt.done = 1'b1;
         end else begin
            st_nxt.acc = total;
            st_nxt.cnt = st_r.cnt + 16'h0001;
            if (cur_ilv) begin
               // The raw sample rides at the native 12-bit alignment.
               st_nxt.data = {4'h0, adc_result};
               st_nxt.valid = 1'b1;
               st_nxt.is_raw = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
         // Latched settings are never read before the first sample replaces them.
         st_r.vbits <= `OSD_RST_VBITS;
         st_r.mode <= osd_pkg::OSD_TRUNC;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign out_data = st_r.data;
   assign out_valid = st_r.valid;
   assign out_is_raw = st_r.is_raw;

   sequence last_sample_s;
      last_sample;
   endsequence

   // A raw step is any taken sample of an interleaved interval but its last.
   sequence raw_step_s;
      adc_valid && !last_sample && cur_ilv;
   endsequence

   one_word_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      last_sample_s |=> out_valid && !out_is_raw)
      else $error("Interval end produced no decimated word.");

   restart_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      last_sample_s |=> st_r.cnt == 16'h0000 && st_r.acc == 16'h0000)
      else $error("Accumulator did not restart at interval end.");

   count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      st_r.cnt <= 16'h000F)
      else $error("Sample count beyond sixteen.");

   trunc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      last_sample && cur_mode == osd_pkg::OSD_TRUNC && eff_vbits == 2'h2
      |=> out_data == {4'h0, $past(total) >> 4})
      else $error("Truncate output wrong.");

   round_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      last_sample && cur_mode == osd_pkg::OSD_ROUND && eff_vbits == 2'h2
      && total[15:4] != 12'hFFF
      |=> out_data == {4'h0, $past(total[15:4]) + {11'h000, $past(total[3])}})
      else $error("Round output wrong.");

   extend_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      last_sample && cur_mode == osd_pkg::OSD_EXTEND && eff_vbits == 2'h2
      |=> out_data == {2'h0, $past(total) >> 2})
      else $error("Extended output is not the upper 14 bits.");

   raw_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      raw_step_s
      |=> out_valid && out_is_raw && out_data == {4'h0, $past(adc_result)})
      else $error("Interleaved raw sample missing.");

   no_raw_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !st_r.ilv && !$past(st_r.ilv) |-> !out_is_raw)
      else $error("Raw sample emitted in decimate-only mode.");

   no_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      adc_valid && !(st_r.cnt == last_count) |=> st_r.acc >= $past(st_r.acc))
      else $error("Accumulator wrapped.");

   data_hold_a: assert property (@(posedge sys_clk)
      disable iff (sys_rst) !out_valid |-> out_data == $past(out_data))
      else $error("Output word changed without a strobe.");

   raw_valid_a: assert property (@(posedge sys_clk)
      disable iff (sys_rst) out_is_raw |-> out_valid)
      else $error("Raw flag raised without a strobe.");

   // Truncate and round must leave the four spare bits of the word clear.
   narrow_word_a: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      last_sample && (cur_mode == osd_pkg::OSD_TRUNC
                      || cur_mode == osd_pkg::OSD_ROUND)
      |=> out_data[15:12] == 4'h0)
      else $error("Native-width word has upper bits set.");

   ext_low_a: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      last_sample && cur_mode == osd_pkg::OSD_EXTEND && eff_vbits != 2'h0
      |=> out_data[0] == $past(total[eff_vbits]))
      else $error("Extended word lost its extra low bit.");

   single_pass_a: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      last_sample && eff_vbits == 2'h0 && cur_mode == osd_pkg::OSD_TRUNC
      |=> out_data == {4'h0, $past(adc_result)})
      else $error("Single-sample interval did not pass the sample.");

   cfg_latch_a: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      adc_valid && start
      |=> st_r.vbits == $past(cfg_vbits) && st_r.ilv == $past(cfg_interleave))
      else $error("Settings not latched at interval start.");

   count_step_a: assert property (@(posedge sys_clk)
      disable iff (sys_rst)
      adc_valid && !last_sample |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
      else $error("Sample count did not advance by one.");

   dec_source_a: assert property (@(posedge sys_clk)
      disable iff (sys_rst) out_valid && !out_is_raw |-> $past(last_sample))
      else $error("Decimated word without an interval end.");

   // Checked during reset as well, so there is no disable clause here.
   reset_quiet_a: assert property (@(posedge sys_clk)
      sys_rst |=> !out_valid && !out_is_raw && out_data == 16'h0000)
      else $error("Outputs not cleared by reset.");
endmodule : osd_decimator

//--- osd_adc_model.sv
// Purpose: Stand-in for the ADC conversion result port.
// Assumes: One strobe per result, changed at the falling edge.
// Notes:   Gap cycles show the inverse of the last value; idle() inverts whatever the lines hold.
`include "osd_consts.svh"
module osd_adc_model (
   input  wire logic                     sys_clk,
   output logic                          adc_valid,
   output logic [`OSD_SAMPLE_W-1:0]      adc_result
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      adc_valid = 1'b0;
      adc_result = 12'h000;
   end
   // A zero gap leaves the strobe high so results arrive back to back.
   task automatic send(input logic [11:0] val, input int gap);
      @(negedge sys_clk);
      adc_valid = 1'b1;
      adc_result = val;
      if (gap > 0) begin
         @(negedge sys_clk);
         adc_valid = 1'b0;
         adc_result = ~val;
         repeat (gap - 1) @(negedge sys_clk);
      end
   endtask : send
   task automatic idle();
      @(negedge sys_clk);
      adc_valid = 1'b0;
      adc_result = ~adc_result;
   endtask : idle
endmodule : osd_adc_model

//--- tb_top.sv
// Purpose: Self-checking bench for the oversample decimator.
// Assumes: 40 MHz sys_clk; inputs change at the falling edge.
// Notes:   Expected words are rebuilt here from the sent samples.
`include "osd_consts.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic                     sys_clk, sys_rst, adc_valid, cfg_interleave;
   logic                     out_valid, out_is_raw;
   logic [`OSD_SAMPLE_W-1:0] adc_result;
   logic [`OSD_VBITS_W-1:0]  cfg_vbits;
   osd_pkg::osd_mode_t       cfg_mode;
   logic [`OSD_SUM_W-1:0]    out_data;
   logic [16:0]              seen[$];
   int                       mismatches, num_checks, cycles;
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   osd_adc_model u_osd_adc_model (.sys_clk(sys_clk), .adc_valid(adc_valid),
      .adc_result(adc_result));
   osd_decimator u_osd_decimator (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .adc_valid(adc_valid), .adc_result(adc_result), .cfg_vbits(cfg_vbits),
      .cfg_mode(cfg_mode), .cfg_interleave(cfg_interleave),
      .out_data(out_data), .out_valid(out_valid), .out_is_raw(out_is_raw));
   // Outputs are taken at the falling edge, half a cycle after they settle.
   always @(negedge sys_clk) begin
      if (out_valid === 1'b1) seen.push_back({out_is_raw, out_data});
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [16:0] want, got);
      num_checks++;
      if (got !== want) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, want, got);
      end
   endtask : check
   // One interval; every output word, raw or decimated, is compared.
   task automatic run(input int n, input osd_pkg::osd_mode_t m,
      input logic il, input logic [11:0] base, step, input int gap);
      logic [15:0] sum;
      logic [11:0] s;
      logic [16:0] dec;
      logic [16:0] want[$];
      int          k;
      k = (n > 2) ? 2 : n;
      sum = 16'h0000;
      @(negedge sys_clk);
      cfg_vbits = 2'(n);
      cfg_mode = m;
      cfg_interleave = il;
      // A setting of three virtual bits is clamped to two by the block.
      for (int i = 0; i < (1 << (2 * k)); i++) begin
         s = base + 12'(i) * step;
         sum = sum + 16'(s);
         if (il && i < (1 << (2 * k)) - 1) want.push_back({5'h10, s});
         u_osd_adc_model.send(s, gap);
      end
      case (m)
         osd_pkg::OSD_ROUND: dec = 17'(sum >> 4) + 17'(sum[3]);
         osd_pkg::OSD_TRUNC: dec = 17'(sum >> (2 * k));
         default: dec = 17'(sum >> k);
      endcase
      want.push_back(dec);
      u_osd_adc_model.idle();
      repeat (3) @(negedge sys_clk);
      check("word count", 17'(want.size()), 17'(seen.size()));
      foreach (want[i]) check("word", want[i], seen[i]);
      seen.delete();
   endtask : run
   // Reset in mid-interval: the partial sum is dropped and nothing comes out.
   task automatic reset_mid();
      for (int i = 0; i < 5; i++) u_osd_adc_model.send(12'hFFF, 0);
      u_osd_adc_model.idle();
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      check("reset words", 17'h0_0000, 17'(seen.size()));
      seen.delete();
   endtask : reset_mid
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   initial begin
      sys_rst = 1'b1;
      cfg_vbits = 2'h2;
      cfg_mode = osd_pkg::OSD_TRUNC;
      cfg_interleave = 1'b0;
      mismatches = 0;
      num_checks = 0;
      cycles = 0;
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      run(2, osd_pkg::OSD_TRUNC, 1'b0, 12'h123, 12'h00D, 0);
      reset_mid();
      run(2, osd_pkg::OSD_ROUND, 1'b0, 12'h008, 12'h00D, 0);
      run(2, osd_pkg::OSD_EXTEND, 1'b0, 12'h7A5, 12'h029, 1);
      run(1, osd_pkg::OSD_EXTEND, 1'b0, 12'h3F1, 12'h105, 0);
      run(0, osd_pkg::OSD_TRUNC, 1'b0, 12'hABC, 12'h000, 2);
      run(2, osd_pkg::OSD_TRUNC, 1'b1, 12'h456, 12'h0F1, 3);
      run(2, osd_pkg::OSD_TRUNC, 1'b0, 12'hFFF, 12'h000, 0);
      run(2, osd_pkg::OSD_ROUND, 1'b1, 12'hFFF, 12'h000, 0);
      run(3, osd_pkg::osd_mode_t'(2'h3), 1'b0, 12'h5A0, 12'h033, 0);
      close_out();
   end
endmodule : tb_top
